// [src/cid_pkg.sv]
// cid_pkg: encodings, field layout and constants of the identification registers
// assumes: included first; shared by the register block and its bench
package cid_pkg;

    // coprocessor read/write request from the pipeline, one cycle wide
    typedef struct packed {
        logic        valid;   // request strobe
        logic        write;   // 1 = write, 0 = read
        logic        priv;    // 1 = privileged mode
        logic [2:0]  opc1;    // first opcode
        logic [3:0]  crn;     // primary register
        logic [3:0]  crm;     // secondary register
        logic [2:0]  opc2;    // second opcode
        logic [31:0] wdata;   // write data
    } cid_req_t;

    // answer, one cycle after the request
    typedef struct packed {
        logic        valid;   // read data valid
        logic        undef;   // access refused
        logic [31:0] data;    // read data
    } cid_rsp_t;

    // register encodings: opc1 / opc2 with crn = crm = c0
    localparam logic [2:0] AFF_OPC1 = 3'h0;
    localparam logic [2:0] AFF_OPC2 = 3'h5;
    localparam logic [2:0] REV_OPC1 = 3'h0;
    localparam logic [2:0] REV_OPC2 = 3'h6;
    localparam logic [2:0] GEO_OPC1 = 3'h1;
    localparam logic [2:0] GEO_OPC2 = 3'h0;
    localparam logic [2:0] SEL_OPC1 = 3'h2;
    localparam logic [2:0] SEL_OPC2 = 3'h0;
    localparam logic [3:0] CR_ZERO  = 4'h0;

    // affinity layout
    localparam int         AFF_FMT_BIT = 31;
    localparam int         AFF_UP_BIT  = 30;
    localparam int         AFF_CLU_LSB = 8;
    localparam int         AFF_CORE_LSB = 0;
    localparam logic       AFF_FMT_VAL = 1'b1;

    // cache geometry layout
    localparam int         GEO_POL_LSB  = 28;
    localparam int         GEO_SETS_LSB = 13;
    localparam int         GEO_WAYS_LSB = 3;
    localparam int         GEO_LINE_LSB = 0;
    localparam logic [3:0] GEO_POL_ICACHE = 4'h2;
    localparam logic [3:0] GEO_POL_DCACHE = 4'h7;
    localparam logic [9:0] GEO_WAYS_VAL   = 10'h003;
    localparam logic [2:0] GEO_LINE_VAL   = 3'h1;
    localparam logic [14:0] GEO_SETS_16K  = 15'h007f;
    localparam logic [14:0] GEO_SETS_32K  = 15'h00ff;
    localparam logic [14:0] GEO_SETS_64K  = 15'h01ff;

    // selection register: bit 0 picks instruction cache, level field reads zero
    localparam int         SEL_IND_BIT = 0;
    localparam logic       SEL_RST     = 1'b0;

    // arbitrary neutral revision value
    localparam logic [31:0] REV_DEFAULT = 32'h0000_0000;

endpackage : cid_pkg

// [src/cid_regs.sv]
// cid_regs: identification registers on the system control coprocessor port
// assumes: pipeline presents one request per cycle, answer taken next cycle;
//          cluster pins are asynchronous straps, core index stable around reset
//
// Contract
// - affinity bit 31 always reads one, marking the multiprocessor format
// - affinity bit 30 reads one for uniprocessor, zero for cluster member
// - affinity bits 11:8 show the synchronised cluster select pins
// - uniprocessor build returns zero in the cluster number field
// - uniprocessor build uses no cluster select pins at all
// - core index in bits 1:0; fixed zero in uniprocessor build
// - affinity is read at opcode 0, c0, c0, 5
// - one revision copy, same value in both security states
// - revision returns a 32-bit value fixed by the implementation
// - revision is read at opcode 0, c0, c0, 6
// - revision and cache geometry refused outside privileged modes
// - cache geometry describes the cache picked by the selection register
// - affinity privileged only, same in both security states
// - geometry bits 31:28 read 0010 for instruction, 0111 for data
// - geometry associativity reads ways minus one, four ways
`timescale 1ns/1ns
`default_nettype none

module cid_regs
    import cid_pkg::*;
#(
    parameter bit          UNIPROC   = 1'b0,         // standalone core build
    parameter logic [31:0] REV_VALUE = REV_DEFAULT,  // arbitrary value
    parameter logic [14:0] CACHE_SETS = GEO_SETS_32K // sets minus one
) (
    input  wire logic            sys_clk,      // core clock, 125 MHz
    input  wire logic            arst_n,       // async reset, active low
    input  wire logic [3:0]      cluster_select_pins, // cluster straps
    input  wire logic [1:0]      core_index,   // core number strap
    input  wire cid_pkg::cid_req_t req,        // coprocessor request
    output var cid_pkg::cid_rsp_t rsp          // registered answer
);
    import cid_pkg::*;

    generate
        if (CACHE_SETS != GEO_SETS_16K && CACHE_SETS != GEO_SETS_32K &&
            CACHE_SETS != GEO_SETS_64K) begin : g_bad_sets
            $error("cid_regs: unsupported cache size");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // reset release and input synchronisers

    logic       rst_s1;
    logic       rst_n;
    logic [3:0] clu_s1;
    logic [3:0] clu_q;
    logic       strap_done;
    logic [1:0] core_q;
    logic       next_strap_done;
    logic [1:0] next_core_q;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end

    // straps may move at any time, so only the second stage is read
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            clu_s1 <= 4'h0;
            clu_q  <= 4'h0;
        end else begin
            clu_s1 <= cluster_select_pins;
            clu_q  <= clu_s1;
        end
    end

    // core strap passes two stages like any pin; they clear on the raw reset only,
    // so the strap is through them before the internal reset lifts
    logic [1:0] core_s1;
    logic [1:0] core_s2;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            core_s1 <= 2'h0;
            core_s2 <= 2'h0;
        end else begin
            core_s1 <= core_index;
            core_s2 <= core_s1;
        end
    end

    // core index is caught once, on the first edge after release
    always_comb begin
        next_strap_done = 1'b1;
        next_core_q     = core_q;
        if (!strap_done)
            next_core_q = UNIPROC ? 2'h0 : core_s2;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_done <= 1'b0;
            core_q     <= 2'h0;
        end else begin
            strap_done <= next_strap_done;
            core_q     <= next_core_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decode

    function automatic logic enc_hit(cid_req_t r, logic [2:0] o1, logic [2:0] o2);
        return r.valid && r.opc1 == o1 && r.opc2 == o2 &&
               r.crn == CR_ZERO && r.crm == CR_ZERO;
    endfunction

    logic hit_aff;
    logic hit_rev;
    logic hit_geo;
    logic hit_sel;
    assign hit_aff = enc_hit(req, AFF_OPC1, AFF_OPC2);
    assign hit_rev = enc_hit(req, REV_OPC1, REV_OPC2);
    assign hit_geo = enc_hit(req, GEO_OPC1, GEO_OPC2);
    assign hit_sel = enc_hit(req, SEL_OPC1, SEL_OPC2);

    ////////////////////////////////////////////////////////////////////////
    // register values; no security state input: one copy serves both

    logic        sel_ind;
    logic [31:0] aff_val;
    logic [31:0] geo_val;

    always_comb begin
        aff_val = 32'h0000_0000;
        aff_val[AFF_FMT_BIT] = AFF_FMT_VAL;
        aff_val[AFF_UP_BIT]  = UNIPROC;
        // uniprocessor build never looks at the cluster pins
        aff_val[AFF_CLU_LSB +: 4] = UNIPROC ? 4'h0 : clu_q;
        aff_val[AFF_CORE_LSB +: 2] = core_q;
    end

    always_comb begin
        geo_val = 32'h0000_0000;
        geo_val[GEO_POL_LSB +: 4] = sel_ind ? GEO_POL_ICACHE : GEO_POL_DCACHE;
        geo_val[GEO_SETS_LSB +: 15] = CACHE_SETS;
        geo_val[GEO_WAYS_LSB +: 10] = GEO_WAYS_VAL;
        geo_val[GEO_LINE_LSB +: 3]  = GEO_LINE_VAL;
    end

    ////////////////////////////////////////////////////////////////////////
    // access and answer

    logic     next_sel_ind;
    cid_rsp_t next_rsp;

    always_comb begin
        next_sel_ind = sel_ind;
        next_rsp     = '0;
        if (req.valid) begin
            if (!req.priv) begin
                next_rsp.undef = 1'b1;
            end else if (hit_sel) begin
                if (req.write)
                    next_sel_ind = req.wdata[SEL_IND_BIT];
                else
                    next_rsp.data[SEL_IND_BIT] = sel_ind;
                next_rsp.valid = !req.write;
            end else if (req.write) begin
                // id registers are read-only; a write is refused unchanged
                next_rsp.undef = 1'b1;
            end else if (hit_aff) begin
                next_rsp.valid = 1'b1;
                next_rsp.data  = aff_val;
            end else if (hit_rev) begin
                next_rsp.valid = 1'b1;
                next_rsp.data  = REV_VALUE;
            end else if (hit_geo) begin
                next_rsp.valid = 1'b1;
                next_rsp.data  = geo_val;
            end else begin
                next_rsp.undef = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_ind <= SEL_RST;
            rsp     <= '0;
        end else begin
            sel_ind <= next_sel_ind;
            rsp     <= next_rsp;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_aff_rd;
        req.valid && req.priv && !req.write && hit_aff;
    endsequence

    sequence s_rev_rd;
        req.valid && req.priv && !req.write && hit_rev;
    endsequence

    sequence s_geo_rd;
        req.valid && req.priv && !req.write && hit_geo;
    endsequence

    sequence s_id_wr;
        req.valid && req.priv && req.write && (hit_aff || hit_rev || hit_geo);
    endsequence

    // every answer is looked at one edge after its request is taken,
    // since it stands for that single cycle only

    a_aff_format: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_aff_rd |=> rsp.valid && rsp.data[31] == 1'b1)
        else $error("affinity format bit not one");

    a_aff_upflag: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_aff_rd |=> rsp.data[30] == UNIPROC)
        else $error("affinity uniprocessor flag wrong");

    a_aff_cluster: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_aff_rd |=> rsp.data[11:8] == (UNIPROC ? 4'h0 : $past(clu_q)))
        else $error("cluster number field wrong");

    a_up_cluster_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
        UNIPROC && rsp.valid && $past(hit_aff) |-> rsp.data[11:8] == 4'h0)
        else $error("uniprocessor cluster field not zero");

    a_aff_core: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_aff_rd ##1 1'b1 |-> rsp.data[1:0] == (UNIPROC ? 2'h0 : core_q))
        else $error("core index field wrong");

    a_aff_reserved: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_aff_rd |=> rsp.data[29:12] == 18'h0 && rsp.data[7:2] == 6'h0)
        else $error("reserved affinity bits not zero");

    a_rev_value: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_rev_rd |=> rsp.valid && !rsp.undef && rsp.data == REV_VALUE)
        else $error("revision value wrong");

    a_user_refused: assert property (@(posedge sys_clk) disable iff (!rst_n)
        req.valid && !req.priv |=> rsp.undef && !rsp.valid && rsp.data == 32'h0)
        else $error("user access not refused");

    a_geo_select: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_geo_rd |=> rsp.data[31:28] == ($past(sel_ind) ? 4'h2 : 4'h7))
        else $error("cache geometry policy bits wrong");

    a_geo_ways: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_geo_rd |=> rsp.data[12:3] == 10'h003)
        else $error("associativity not four ways");

    a_sel_steers: assert property (@(posedge sys_clk) disable iff (!rst_n)
        req.valid && req.priv && req.write && hit_sel ##1 s_geo_rd
        |=> rsp.data[31:28] == ($past(req.wdata[0], 2) ? 4'h2 : 4'h7))
        else $error("selection write did not steer geometry");

    a_id_write_refused: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_id_wr |=> rsp.undef && !rsp.valid)
        else $error("write to identification register not refused");

    a_id_write_keeps: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_id_wr |=> $stable(sel_ind))
        else $error("refused write changed the selection");

    a_aff_privileged: assert property (@(posedge sys_clk) disable iff (!rst_n)
        req.valid && !req.priv && hit_aff |=> rsp.undef && rsp.data == 32'h0)
        else $error("user read of affinity not refused");

    a_sel_readback: assert property (@(posedge sys_clk) disable iff (!rst_n)
        req.valid && req.priv && !req.write && hit_sel
        |=> rsp.valid && rsp.data == {31'h0, $past(sel_ind)})
        else $error("selection read-back wrong");

    a_geo_fields: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_geo_rd |=> rsp.data[27:13] == CACHE_SETS && rsp.data[2:0] == 3'h1)
        else $error("cache geometry size fields wrong");

    a_unmapped_refused: assert property (@(posedge sys_clk) disable iff (!rst_n)
        req.valid && req.priv && !(hit_aff || hit_rev || hit_geo || hit_sel)
        |=> rsp.undef && !rsp.valid)
        else $error("unmapped encoding not refused");

    a_answer_once: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rsp.valid || rsp.undef |-> $past(req.valid) && !(rsp.valid && rsp.undef))
        else $error("answer without request");

    a_core_steady: assert property (@(posedge sys_clk) disable iff (!rst_n)
        strap_done |=> $stable(core_q))
        else $error("core index moved after capture");

endmodule : cid_regs

`default_nettype wire

// [verification/cid_regs_test.sv]
// cid_regs_test: self-checking bench for the identification registers
// assumes: cid_pkg compiled first; cluster and uniprocessor builds share one request
`timescale 1ns/1ns
`default_nettype none

module cid_regs_test;
    import cid_pkg::*;

    localparam logic [31:0] REV_A = 32'h5a3c_9e17; // arbitrary revision value
    logic        sys_clk;
    logic        arst_n;
    logic [3:0]  cluster_select_pins;
    logic [1:0]  core_index;
    cid_req_t    req;
    cid_rsp_t    rsp_main;
    cid_rsp_t    rsp_up;
    cid_rsp_t    ra;
    cid_rsp_t    rb;
    int          errors;
    int          samples_checked;
    int          cycles;
    int          seed_dummy;

    cid_regs #(.UNIPROC(1'b0), .REV_VALUE(REV_A)) cid_regs_inst (
        .sys_clk(sys_clk), .arst_n(arst_n), .cluster_select_pins(cluster_select_pins),
        .core_index(core_index), .req(req), .rsp(rsp_main));
    // uniprocessor build: sees the same moving straps and must ignore them
    cid_regs #(.UNIPROC(1'b1)) cid_regs_inst_up (
        .sys_clk(sys_clk), .arst_n(arst_n), .cluster_select_pins(cluster_select_pins),
        .core_index(core_index), .req(req), .rsp(rsp_up));

    always #4 sys_clk = ~sys_clk;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] exp_aff(logic up, logic [3:0] clu, logic [1:0] core);
        return {1'b1, up, 18'h0, up ? 4'h0 : clu, 6'h0, up ? 2'h0 : core};
    endfunction

    function automatic logic [31:0] exp_geo(logic [3:0] pol);
        return {pol, GEO_SETS_32K, GEO_WAYS_VAL, GEO_LINE_VAL};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // one request, answer sampled mid-cycle after the answering edge
    task automatic access(input logic wr, input logic pv, input logic [2:0] o1,
                          input logic [3:0] cm, input logic [2:0] o2, input logic [31:0] wd);
        @(negedge sys_clk);
        req = '{1'b1, wr, pv, o1, CR_ZERO, cm, o2, wd};
        @(negedge sys_clk);
        ra = rsp_main;
        rb = rsp_up;
        req.valid = 1'b0;
    endtask

    task automatic chk(input cid_rsp_t r, input logic v, input logic u, input logic [31:0] d);
        check({30'h0, r.valid, r.undef}, {30'h0, v, u});
        check(r.data, d);
    endtask

    // refused access: both builds answer undef with zero data
    task automatic refuse(input logic wr, input logic pv, input logic [2:0] o1,
                          input logic [3:0] cm, input logic [2:0] o2);
        access(wr, pv, o1, cm, o2, $urandom);
        chk(ra, 1'b0, 1'b1, 32'h0);
        chk(rb, 1'b0, 1'b1, 32'h0);
    endtask

    task automatic do_reset;
        arst_n = 1'b0;
        repeat (20) @(negedge sys_clk);
        arst_n = 1'b1;
        repeat (5) @(negedge sys_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            test_done();
        end
    end

    initial begin
        sys_clk = 1'b0;
        arst_n = 1'b0;
        req = '0;
        cluster_select_pins = 4'h0;
        core_index = 2'h0;
        errors = 0;
        samples_checked = 0;
        cycles = 0;
        seed_dummy = $urandom(4);
        // every core index, each under a fresh reset
        for (int c = 0; c < 4; c++) begin
            core_index = c[1:0];
            cluster_select_pins = (c == 3) ? 4'hf : 4'($urandom);
            do_reset();
            access(1'b0, 1'b1, AFF_OPC1, CR_ZERO, AFF_OPC2, 32'h0);
            chk(ra, 1'b1, 1'b0, exp_aff(1'b0, cluster_select_pins, core_index));
            chk(rb, 1'b1, 1'b0, exp_aff(1'b1, cluster_select_pins, core_index));
        end
        // cluster straps change at run time
        for (int i = 0; i < 16; i++) begin
            cluster_select_pins = 4'($urandom);
            repeat (2) @(negedge sys_clk);
            access(1'b0, 1'b1, AFF_OPC1, CR_ZERO, AFF_OPC2, 32'h0);
            check(ra.data, exp_aff(1'b0, cluster_select_pins, core_index));
        end
        refuse(1'b0, 1'b0, REV_OPC1, CR_ZERO, REV_OPC2);
        refuse(1'b0, 1'b0, GEO_OPC1, CR_ZERO, GEO_OPC2);
        refuse(1'b0, 1'b0, AFF_OPC1, CR_ZERO, AFF_OPC2);
        refuse(1'b1, 1'b1, AFF_OPC1, CR_ZERO, AFF_OPC2);
        refuse(1'b1, 1'b1, REV_OPC1, CR_ZERO, REV_OPC2);
        refuse(1'b0, 1'b1, AFF_OPC1, 4'h1, AFF_OPC2);
        // writes above must not have altered anything
        access(1'b0, 1'b1, REV_OPC1, CR_ZERO, REV_OPC2, 32'h0);
        chk(ra, 1'b1, 1'b0, REV_A);
        chk(rb, 1'b1, 1'b0, REV_DEFAULT);
        access(1'b0, 1'b1, AFF_OPC1, CR_ZERO, AFF_OPC2, 32'h0);
        check(ra.data, exp_aff(1'b0, cluster_select_pins, core_index));
        // geometry follows the selection; data cache after reset
        access(1'b0, 1'b1, GEO_OPC1, CR_ZERO, GEO_OPC2, 32'h0);
        chk(ra, 1'b1, 1'b0, exp_geo(GEO_POL_DCACHE));
        access(1'b1, 1'b1, SEL_OPC1, CR_ZERO, SEL_OPC2, {31'($urandom), 1'b1});
        chk(ra, 1'b0, 1'b0, 32'h0);
        access(1'b0, 1'b1, GEO_OPC1, CR_ZERO, GEO_OPC2, 32'h0);
        chk(ra, 1'b1, 1'b0, exp_geo(GEO_POL_ICACHE));
        access(1'b1, 1'b1, SEL_OPC1, CR_ZERO, SEL_OPC2, 32'hffff_fffe);
        access(1'b0, 1'b1, GEO_OPC1, CR_ZERO, GEO_OPC2, 32'h0);
        chk(ra, 1'b1, 1'b0, exp_geo(GEO_POL_DCACHE));
        // back to back: selection write, geometry read, selection read-back
        @(negedge sys_clk);
        req = '{1'b1, 1'b1, 1'b1, SEL_OPC1, CR_ZERO, CR_ZERO, SEL_OPC2, 32'h0000_0001};
        @(negedge sys_clk);
        check({31'h0, rsp_main.valid}, 32'h0);
        req = '{1'b1, 1'b0, 1'b1, GEO_OPC1, CR_ZERO, CR_ZERO, GEO_OPC2, 32'h0};
        @(negedge sys_clk);
        check(rsp_main.data, exp_geo(GEO_POL_ICACHE));
        req = '{1'b1, 1'b0, 1'b1, SEL_OPC1, CR_ZERO, CR_ZERO, SEL_OPC2, 32'h0};
        @(negedge sys_clk);
        check(rsp_main.data, 32'h0000_0001);
        req.valid = 1'b0;
        test_done();
    end

endmodule // cid_regs_test

`default_nettype wire
